// ==== common/pic_consts.svh ====
`ifndef PIC_CONSTS_SVH
`define PIC_CONSTS_SVH
// ----------------------------------------
// Bus address and register offsets
// ----------------------------------------
`define PIC_WRITE_ADDR      8'h98
`define PIC_OFS_CHARGER     8'h00
`define PIC_OFS_SYS_REG1    8'h01
`define PIC_OFS_REGS2TO5    8'h02
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PIC_TERM_LSB        0
`define PIC_CHG_LSB         2
`define PIC_RECHARGE_THRESHOLD_CODE_LSB        5
`define PIC_WDOG_BIT        7
`define PIC_SYS_BIT         2
// ----------------------------------------
// Reset values, forced code and bits per byte
// ----------------------------------------
`define PIC_RESET_BYTE      8'h00
`define PIC_CHG_FORCED      3'h0
`define PIC_BITS_PER_BYTE   4'h8
`endif

// ==== common/pic_line_if.sv ====
`timescale 1ns/1ps
// Synchronised bus line levels and detected events
interface pic_line_if;
	logic scl_rise;
	logic scl_fall;
	logic scl_high;
	logic sda_level;
	logic start_seen;
	logic stop_seen;
	modport producer (output scl_rise, scl_fall, scl_high, sda_level, start_seen, stop_seen);
	modport consumer (input scl_rise, scl_fall, scl_high, sda_level, start_seen, stop_seen);
endinterface : pic_line_if

// ==== common/pic_pkg.sv ====
package pic_pkg;
	typedef enum logic [2:0] {
		PIC_IDLE,
		PIC_ADDR,
		PIC_SEL,
		PIC_DATA,
		PIC_IGNORE
	} pic_phase_type;
endpackage : pic_pkg

// ==== design/pic_line_sync.sv ====
`timescale 1ns/1ps
module pic_line_sync
	import pic_pkg::*;
(
	input  wire logic   sys_clk,
	input  wire logic   sys_rst,
	input  wire logic   scl_in,
	input  wire logic   sda_in,
	pic_line_if.producer line
);
	typedef struct packed {
		logic [1:0] scl_sync;
		logic [1:0] sda_sync;
		logic       scl_prev;
		logic       sda_prev;
	} pic_sync_type;

	pic_sync_type state_reg;
	pic_sync_type state_next;

	// --------------------------------
	// Two-stage synchronisers and history
	// --------------------------------
	always_comb begin
		state_next          = state_reg;
		state_next.scl_sync = {state_reg.scl_sync[0], scl_in};
		state_next.sda_sync = {state_reg.sda_sync[0], sda_in};
		state_next.scl_prev = state_reg.scl_sync[1];
		state_next.sda_prev = state_reg.sda_sync[1];
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_prev: 1'b1, sda_prev: 1'b1};
		end else begin
			state_reg <= state_next;
		end
	end

	// Edge and condition detection on synchronised levels
	assign line.scl_rise   = state_reg.scl_sync[1] & ~state_reg.scl_prev;
	assign line.scl_fall   = ~state_reg.scl_sync[1] & state_reg.scl_prev;
	assign line.scl_high   = state_reg.scl_sync[1];
	assign line.sda_level  = state_reg.sda_sync[1];
	assign line.start_seen = state_reg.scl_sync[1] & state_reg.scl_prev
		& state_reg.sda_prev & ~state_reg.sda_sync[1];
	assign line.stop_seen  = state_reg.scl_sync[1] & state_reg.scl_prev
		& ~state_reg.sda_prev & state_reg.sda_sync[1];
endmodule : pic_line_sync

// ==== design/pic_write_config.sv ====
`timescale 1ns/1ps
`include "pic_consts.svh"
module pic_write_config
	import pic_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       power_key_in,
	input  wire logic       power_hold_in,
	input  wire logic       adapter_supply_input,
	input  wire logic       cell_supply,
	output logic [2:0]      charge_current_code,
	output logic [1:0]      termination_code,
	output logic [1:0]      recharge_threshold_code,
	output logic            watchdog_stop,
	output logic            extra_system_control_bit,
	output logic [1:0]      first_regulator_voltage_code,
	output logic [1:0]      second_regulator_voltage_code,
	output logic [1:0]      third_regulator_voltage_code,
	output logic [1:0]      fourth_regulator_voltage_code,
	output logic [1:0]      fifth_regulator_voltage_code
);
	typedef struct packed {
		pic_phase_type phase;
		logic [7:0]    shift;
		logic [3:0]    bit_cnt;
		logic          in_ack;
		logic          ack_drive;
		logic [7:0]    sel;
		logic [7:0]    charger_config;
		logic [7:0]    system_and_first_regulator_config;
		logic [7:0]    regulators_two_to_five_voltage;
		logic          forced;
		logic          key_started;
		logic          powered;
		logic [2:0]    pwr_sync_key;
		logic [2:0]    pwr_sync_hold;
		logic [2:0]    pwr_sync_adp;
		logic [2:0]    pwr_sync_cell;
		logic [2:0]    chg_out;
	} pic_top_type;

	pic_top_type state_reg;
	pic_top_type state_next;

	pic_line_if line ();

	// --------------------------------
	// Bus line synchronisation
	// --------------------------------
	pic_line_sync u_sync (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.line    (line.producer)
	);

	logic [7:0] byte_in;
	logic       key_lvl;
	logic       hold_lvl;
	logic       adp_lvl;
	logic       cell_lvl;
	logic       adp_prev;
	logic       adp_fall;
	logic       adp_rise;

	// Stage index 1 is the second synchroniser flop; index 2 is history
	assign byte_in  = {state_reg.shift[6:0], line.sda_level};
	assign key_lvl  = state_reg.pwr_sync_key[1];
	assign hold_lvl = state_reg.pwr_sync_hold[1];
	assign adp_lvl  = state_reg.pwr_sync_adp[1];
	assign cell_lvl = state_reg.pwr_sync_cell[1];
	assign adp_prev = state_reg.pwr_sync_adp[2];
	assign adp_fall = adp_prev & ~adp_lvl;
	assign adp_rise = ~adp_prev & adp_lvl;

	// --------------------------------
	// Next-state logic
	// --------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.pwr_sync_key  = {state_reg.pwr_sync_key[1:0], power_key_in};
		state_next.pwr_sync_hold = {state_reg.pwr_sync_hold[1:0], power_hold_in};
		state_next.pwr_sync_adp  = {state_reg.pwr_sync_adp[1:0], adapter_supply_input};
		state_next.pwr_sync_cell = {state_reg.pwr_sync_cell[1:0], cell_supply};

		// Power-on source tracking
		if (!state_reg.powered) begin
			if (key_lvl && (adp_lvl || cell_lvl)) begin
				state_next.powered     = 1'b1;
				state_next.key_started = 1'b1;
			end else if (adp_rise) begin
				state_next.powered     = 1'b1;
				state_next.key_started = 1'b0;
			end
		end else if (!state_reg.key_started) begin
			if (key_lvl) begin
				state_next.key_started = 1'b1;
			end
		end

		// Serial byte engine
		if (line.scl_rise && !state_reg.in_ack) begin
			state_next.shift   = byte_in;
			state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
		end
		if (line.scl_fall) begin
			if (state_reg.in_ack) begin
				// End of ninth bit: release data line
				state_next.in_ack    = 1'b0;
				state_next.ack_drive = 1'b0;
				state_next.bit_cnt   = 4'h0;
			end else if (state_reg.bit_cnt == `PIC_BITS_PER_BYTE) begin
				state_next.in_ack = 1'b1;
				case (state_reg.phase)
					PIC_ADDR: begin
						if (state_reg.shift == `PIC_WRITE_ADDR) begin
							state_next.ack_drive = 1'b1;
							state_next.phase     = PIC_SEL;
						end else begin
							state_next.phase = PIC_IGNORE;
						end
					end
					PIC_SEL: begin
						state_next.ack_drive = 1'b1;
						state_next.sel       = state_reg.shift;
						state_next.phase     = PIC_DATA;
					end
					PIC_DATA: begin
						state_next.ack_drive = 1'b1;
						state_next.phase     = PIC_SEL;
						if (state_reg.sel == `PIC_OFS_CHARGER) begin
							state_next.charger_config = state_reg.shift;
						end else if (state_reg.sel == `PIC_OFS_SYS_REG1) begin
							state_next.system_and_first_regulator_config = state_reg.shift;
						end else if (state_reg.sel == `PIC_OFS_REGS2TO5) begin
							state_next.regulators_two_to_five_voltage = state_reg.shift;
						end
						// Other selects leave every register untouched
						if (state_reg.sel <= `PIC_OFS_REGS2TO5) begin
							state_next.forced = 1'b0;
						end
					end
					default: begin
						state_next.in_ack = 1'b0;
						state_next.phase  = PIC_IGNORE;
					end
				endcase
			end
		end

		// Start and stop conditions override the byte engine
		if (line.start_seen) begin
			state_next.phase     = PIC_ADDR;
			state_next.bit_cnt   = 4'h0;
			state_next.in_ack    = 1'b0;
			state_next.ack_drive = 1'b0;
		end else if (line.stop_seen) begin
			state_next.phase     = PIC_IDLE;
			state_next.bit_cnt   = 4'h0;
			state_next.in_ack    = 1'b0;
			state_next.ack_drive = 1'b0;
		end

		// Adapter reconnect on a key-started part forces the charge code
		if (state_reg.powered && state_reg.key_started && adp_rise) begin
			state_next.forced = 1'b1;
		end

		// Shutdown clears every written register
		if (state_reg.powered && ((state_reg.key_started && !hold_lvl && !key_lvl)
			|| (!adp_lvl && !cell_lvl)
			|| (!state_reg.key_started && adp_fall))) begin
			state_next.powered     = 1'b0;
			state_next.key_started = 1'b0;
			state_next.forced      = 1'b0;
			state_next.charger_config                    = `PIC_RESET_BYTE;
			state_next.system_and_first_regulator_config = `PIC_RESET_BYTE;
			state_next.regulators_two_to_five_voltage    = `PIC_RESET_BYTE;
		end

		state_next.chg_out = state_next.forced ? `PIC_CHG_FORCED
			: state_next.charger_config[`PIC_CHG_LSB +: 3];
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// --------------------------------
	// Outputs straight from flip-flops, except the data pin output tied low
	// --------------------------------
	assign sda_out = 1'b0;
	assign sda_oe  = state_reg.ack_drive;
	assign charge_current_code           = state_reg.chg_out;
	assign termination_code              = state_reg.charger_config[`PIC_TERM_LSB +: 2];
	assign recharge_threshold_code       = state_reg.charger_config[`PIC_RECHARGE_THRESHOLD_CODE_LSB +: 2];
	assign watchdog_stop                 = state_reg.charger_config[`PIC_WDOG_BIT];
	assign extra_system_control_bit      = state_reg.system_and_first_regulator_config[`PIC_SYS_BIT];
	assign first_regulator_voltage_code  = state_reg.system_and_first_regulator_config[1:0];
	assign second_regulator_voltage_code = state_reg.regulators_two_to_five_voltage[1:0];
	assign third_regulator_voltage_code  = state_reg.regulators_two_to_five_voltage[3:2];
	assign fourth_regulator_voltage_code = state_reg.regulators_two_to_five_voltage[5:4];
	assign fifth_regulator_voltage_code  = state_reg.regulators_two_to_five_voltage[7:6];
endmodule : pic_write_config

// ==== tb/pic_bus_master.sv ====
`timescale 1ns/1ps
// Bus master writing frames with a 320 ns bus clock
module pic_bus_master (
	input  wire logic sys_clk,
	input  wire logic sda_line,
	output logic      scl_pin,
	output logic      sda_pull
);
	// Both lines released outside frames
	initial begin
		scl_pin = 1'b1;
		sda_pull = 1'b0;
	end
	// Waits n clocks; two make a quarter bus period
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	// Data falls while clock high, then clock falls
	task automatic start_bit();
		sda_pull <= 1'b1;
		tick(2);
		scl_pin <= 1'b0;
		tick(2);
	endtask : start_bit
	// Clock rises, then data rises; no acknowledge
	task automatic stop_bit();
		sda_pull <= 1'b1;
		tick(2);
		scl_pin <= 1'b1;
		tick(2);
		sda_pull <= 1'b0;
		tick(4);
	endtask : stop_bit
	// Eight bits first, then the line released for the ninth
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_pull <= ~b[i];
			tick(2);
			scl_pin <= 1'b1;
			tick(4);
			scl_pin <= 1'b0;
			tick(2);
		end
		sda_pull <= 1'b0;
		tick(2);
		scl_pin <= 1'b1;
		tick(2);
		ack = ~sda_line;
		tick(2);
		scl_pin <= 1'b0;
		tick(2);
	endtask : put_byte
endmodule : pic_bus_master

// ==== tb/pic_cfg_chk.sv ====
`timescale 1ns/1ps
// Watches the bus pins, the supply pins and three of the configuration outputs
module pic_cfg_chk (
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic       power_key_in,
	input wire logic       power_hold_in,
	input wire logic       adapter_supply_input,
	input wire logic       cell_supply,
	input wire logic [2:0] charge_current_code,
	input wire logic [1:0] termination_code,
	input wire logic [1:0] first_regulator_voltage_code
);
	int              rise_cnt_reg;
	wire logic [6:0] codes = {charge_current_code, termination_code, first_regulator_voltage_code};
	default clocking ck @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	// Counts bus clock rises since the last start
	always_ff @(posedge sys_clk) begin
		if (sys_rst || (scl_in && $fell(sda_in)))
			rise_cnt_reg <= 0;
		else if ($rose(scl_in))
			rise_cnt_reg <= rise_cnt_reg + 1;
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	no_read_a: assert property (sda_out == 1'b0) else $error("data pin driven high");
	ack_ninth_a: assert property (
		$rose(sda_oe) |-> rise_cnt_reg inside {8, 9, 17, 18, 26, 27})
		else $error("ack not after a whole byte");
	ack_stands_a: assert property ($rose(sda_oe) |-> sda_oe[*4]) else $error("ack cut short");
	ack_ends_a: assert property ($rose(sda_oe) |-> ##[5:16] !sda_oe) else $error("ack held");
	force_charge_a: assert property (
		$rose(adapter_supply_input) && power_key_in && cell_supply |-> ##[1:8] charge_current_code == 3'h0)
		else $error("charge code not forced");
	hold_clear_a: assert property (
		$fell(power_hold_in) && !power_key_in && !adapter_supply_input |-> ##[1:8] codes == 7'h00)
		else $error("codes kept after hold release");
	supply_clear_a: assert property (
		$fell(adapter_supply_input) && !cell_supply |-> ##[1:8] codes == 7'h00)
		else $error("codes kept after supply loss");
	codes_kept_a: assert property (
		(power_key_in && scl_in && sda_in && $stable(adapter_supply_input)
			&& $stable(cell_supply))[*8] |=> $stable(codes))
		else $error("codes changed while idle");
endmodule : pic_cfg_chk
bind pic_write_config pic_cfg_chk u_pic_cfg_chk (
	.sys_clk                      (sys_clk),
	.sys_rst                      (sys_rst),
	.scl_in                       (scl_in),
	.sda_in                       (sda_in),
	.sda_out                      (sda_out),
	.sda_oe                       (sda_oe),
	.power_key_in                 (power_key_in),
	.power_hold_in                (power_hold_in),
	.adapter_supply_input         (adapter_supply_input),
	.cell_supply                  (cell_supply),
	.charge_current_code          (charge_current_code),
	.termination_code             (termination_code),
	.first_regulator_voltage_code (first_regulator_voltage_code)
);

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
// Configuration writer driven through its bus and supply pins
module testbench;
	logic            sys_clk = 1'b0;
	logic            sys_rst = 1'b1;
	logic            power_key_in = 1'b0;
	logic            power_hold_in = 1'b1;
	logic            adapter_supply_input = 1'b0;
	logic            cell_supply = 1'b1;
	logic            scl_in, sda_pull, sda_out, sda_oe, watchdog_stop, extra_system_control_bit;
	logic [2:0]      charge_current_code;
	logic [1:0]      termination_code, recharge_threshold_code, first_regulator_voltage_code;
	logic [1:0]      second_regulator_voltage_code, third_regulator_voltage_code;
	logic [1:0]      fourth_regulator_voltage_code, fifth_regulator_voltage_code;
	wire logic       sda_in = ~(sda_pull | sda_oe);
	wire logic [7:0] view0 = {watchdog_stop, recharge_threshold_code, charge_current_code,
		termination_code};
	wire logic [7:0] view1 = {5'h00, extra_system_control_bit, first_regulator_voltage_code};
	wire logic [7:0] view2 = {fifth_regulator_voltage_code, fourth_regulator_voltage_code,
		third_regulator_voltage_code, second_regulator_voltage_code};
	int              miscompares = 0;
	int              n_checks = 0;
	always #20 sys_clk = ~sys_clk;
	pic_bus_master u_pic_bus_master (.sys_clk, .sda_line(sda_in), .scl_pin(scl_in), .sda_pull);
	pic_write_config u_pic_write_config (
		.sys_clk, .sys_rst, .scl_in, .sda_in, .sda_out, .sda_oe, .power_key_in, .power_hold_in,
		.adapter_supply_input, .cell_supply, .charge_current_code, .termination_code,
		.recharge_threshold_code, .watchdog_stop, .extra_system_control_bit,
		.first_regulator_voltage_code, .second_regulator_voltage_code,
		.third_regulator_voltage_code, .fourth_regulator_voltage_code, .fifth_regulator_voltage_code
	);
	// Prints the counts and the verdict
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : wrap_up
	// Counts a comparison and reports a difference
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// Lets pin changes reach the outputs
	task automatic settle();
		repeat (8) @(posedge sys_clk);
	endtask : settle
	// Whole frame: start, address, select, data, stop
	task automatic frame(input logic [7:0] adr, sel, dat, input logic [2:0] exp_ack);
		logic [2:0] acks;
		u_pic_bus_master.start_bit();
		u_pic_bus_master.put_byte(adr, acks[2]);
		u_pic_bus_master.put_byte(sel, acks[1]);
		u_pic_bus_master.put_byte(dat, acks[0]);
		u_pic_bus_master.stop_bit();
		settle();
		check("ack", {5'h00, exp_ack}, {5'h00, acks});
	endtask : frame
	// Compares the three register views
	task automatic regs(input logic [7:0] r0, r1, r2);
		check("reg0", r0, view0);
		check("reg1", r1, view1);
		check("reg2", r2, view2);
	endtask : regs
	// Main sequence
	initial begin
		logic [7:0] d0, d1, d2;
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		regs(8'h00, 8'h00, 8'h00);
		power_key_in <= 1'b1;
		settle();
		d1 = 8'h00;
		d2 = 8'h00;
		for (int i = 0; i < 8; i++) begin
			d0 = {i[0], i[1:0], i[2:0], i[1:0]};
			frame(8'h98, 8'h00, d0, 3'b111);
			regs(d0, d1, d2);
		end
		for (int i = 0; i < 4; i++) begin
			d1 = {5'h00, i[0], i[1:0]};
			d2 = {4{i[1:0]}};
			frame(8'h98, 8'h01, d1, 3'b111);
			frame(8'h98, 8'h02, d2, 3'b111);
			regs(d0, d1, d2);
		end
		d0 = 8'h48;
		frame(8'h98, 8'h00, d0, 3'b111);
		frame(8'h99, 8'h00, 8'h00, 3'b000);
		frame(8'h9a, 8'h01, 8'h00, 3'b000);
		frame(8'h98, 8'h03, 8'h00, 3'b111);
		regs(d0, d1, d2);
		adapter_supply_input <= 1'b1;
		settle();
		regs(8'h40, d1, d2);
		frame(8'h98, 8'h05, 8'h00, 3'b111);
		regs(8'h40, d1, d2);
		d2 = 8'h1b;
		frame(8'h98, 8'h02, d2, 3'b111);
		regs(d0, d1, d2);
		adapter_supply_input <= 1'b0;
		settle();
		regs(d0, d1, d2);
		power_key_in <= 1'b0;
		settle();
		power_hold_in <= 1'b0;
		settle();
		regs(8'h00, 8'h00, 8'h00);
		adapter_supply_input <= 1'b1;
		settle();
		frame(8'h98, 8'h01, 8'h06, 3'b111);
		cell_supply <= 1'b0;
		settle();
		regs(8'h00, 8'h06, 8'h00);
		adapter_supply_input <= 1'b0;
		settle();
		regs(8'h00, 8'h00, 8'h00);
		// Key start on the cell alone, then the last supply goes away
		cell_supply <= 1'b1;
		power_key_in <= 1'b1;
		settle();
		frame(8'h98, 8'h02, 8'h1b, 3'b111);
		regs(8'h00, 8'h00, 8'h1b);
		cell_supply <= 1'b0;
		settle();
		regs(8'h00, 8'h00, 8'h00);
		wrap_up();
	end
	// Cuts a hung run short
	initial begin
		#2000000;
		miscompares++;
		wrap_up();
	end
endmodule : testbench
